// [common/t8cw_defines.svh]
// constants of the 8-bit timer with compare and waveform output
// assumes a word-addressed AXI4-Lite map, index times four
`ifndef T8CW_DEFINES_SVH
`define T8CW_DEFINES_SVH
// register indices, byte address is four times the index
`define T8CW_IDX_CTRL_A  8'h24
`define T8CW_IDX_CTRL_B  8'h26
`define T8CW_IDX_COUNT   8'h27
`define T8CW_IDX_COMPARE 8'h28
`define T8CW_IDX_FLAG    8'h15
`define T8CW_IDX_MASK    8'h2E
`define T8CW_IDX_ASYNC   8'h29
`define T8CW_IDX_HI      9
`define T8CW_IDX_LO      2
// fields
`define T8CW_WGM_HI      1
`define T8CW_WGM_LO      0
`define T8CW_COM_HI      7
`define T8CW_COM_LO      6
`define T8CW_FOC_BIT     7
`define T8CW_CS_HI       2
`define T8CW_CS_LO       0
`define T8CW_OVF_BIT     0
`define T8CW_CMF_BIT     1
`define T8CW_ASYNC_BIT   0
// values
`define T8CW_RST8        8'h00
`define T8CW_MAX         8'hFF
`define T8CW_BOTTOM      8'h00
`define T8CW_CS_STOP     3'h0
`define T8CW_RESP_OKAY   2'h0
`define T8CW_RESP_SLVERR 2'h2
// prescaler tap masks, divisor minus one
`define T8CW_DIV8_M      10'h007
`define T8CW_DIV32_M     10'h01F
`define T8CW_DIV64_M     10'h03F
`define T8CW_DIV128_M    10'h07F
`define T8CW_DIV256_M    10'h0FF
`define T8CW_DIV1024_M   10'h3FF
`endif

// [common/t8cw_pkg.sv]
// types of the 8-bit timer with compare and waveform output
// assumes nothing beyond the defines header
package t8cw_pkg;
  typedef enum logic [1:0] {
    T8CW_NORMAL = 2'h0,
    T8CW_PHASE  = 2'h1,
    T8CW_CTC    = 2'h2,
    T8CW_FAST   = 2'h3
  } t8cw_mode_t;
  typedef enum logic [2:0] {
    T8CW_SEL_CA, T8CW_SEL_CB, T8CW_SEL_CNT, T8CW_SEL_CMP,
    T8CW_SEL_FLG, T8CW_SEL_MSK, T8CW_SEL_ASY, T8CW_SEL_NONE
  } t8cw_sel_t;
endpackage : t8cw_pkg

// [hdl/t8cw_top.sv]
// 8-bit timer, one compare channel, waveform output, AXI4-Lite slave
// assumes inputs synchronous to aclk; crystal_clk_in sampled by aclk
// Operation
// - clock select zero stops the tick and holds the count
// - count is readable and writable at any time
// - a software write to the count beats clear or count
// - each tick clears, increments or decrements count per mode
// - count equal compare gives match; flag set on that tick
// - compare enable high raises request while compare flag set
// - compare flag clears when its interrupt is serviced
// - writing one clears the compare flag, zero leaves it
// - mode 0 normal, 1 phase pwm, 2 clear on match, 3 fast pwm
// - compare buffered; immediate in non-pwm, at top in pwm
// - overflow flag at max, or at bottom in phase pwm
// - mode field in control A bits 1:0 sets sequence and top
// - waveform output from match, mode and output action field
// - force strobe in non-pwm applies a match to the output
// - forced match sets no flag and clears no count
// - force strobe stores nothing and reads as zero
// - control B bits 6:3 ignore writes and read zero
// - flags shown unmasked in flag register; requests masked per bit
// - tick from prescaled clock or crystal, async bit chooses
//
// Chosen here: the AXI4-Lite slave port.
`include "t8cw_defines.svh"
module t8cw_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              crystal_clk_in,
  input  wire logic              compare_irq_ack,
  input  wire logic              overflow_irq_ack,
  output logic                   compare_irq,
  output logic                   overflow_irq,
  output logic                   compare_output_pin
);
  ////////////////////////////////////////////////////////////////////
  function automatic t8cw_pkg::t8cw_sel_t decode(
    input logic [ADDR_W-1:0] a);
    case (a[`T8CW_IDX_HI:`T8CW_IDX_LO])
      `T8CW_IDX_CTRL_A:  decode = t8cw_pkg::T8CW_SEL_CA;
      `T8CW_IDX_CTRL_B:  decode = t8cw_pkg::T8CW_SEL_CB;
      `T8CW_IDX_COUNT:   decode = t8cw_pkg::T8CW_SEL_CNT;
      `T8CW_IDX_COMPARE: decode = t8cw_pkg::T8CW_SEL_CMP;
      `T8CW_IDX_FLAG:    decode = t8cw_pkg::T8CW_SEL_FLG;
      `T8CW_IDX_MASK:    decode = t8cw_pkg::T8CW_SEL_MSK;
      `T8CW_IDX_ASYNC:   decode = t8cw_pkg::T8CW_SEL_ASY;
      default:           decode = t8cw_pkg::T8CW_SEL_NONE;
    endcase
  endfunction : decode

  // assumed tap order; codes 6 and 7 fill the gaps
  function automatic logic tap_hit(input logic [2:0] cs,
                                   input logic [9:0] p);
    logic [9:0] m;
    case (cs)
      3'h1:    m = 10'h000;
      3'h2:    m = `T8CW_DIV8_M;
      3'h3:    m = `T8CW_DIV64_M;
      3'h4:    m = `T8CW_DIV256_M;
      3'h5:    m = `T8CW_DIV1024_M;
      3'h6:    m = `T8CW_DIV32_M;
      default: m = `T8CW_DIV128_M;
    endcase
    tap_hit = (p & m) == m;
  endfunction : tap_hit

  ////////////////////////////////////////////////////////////////////
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wdata_q;
  logic              wlane_q, aw_have_q, w_have_q;
  logic [7:0]        ctrl_a_q, cnt_q, cnt_d, ocr_buf_q, ocr_act_q;
  logic [2:0]        cs_q;
  logic [1:0]        mask_q;
  logic              async_q, xtal_prev_q, dir_q, dir_d;
  logic              cmf_q, ovf_q, oc_q, oc_d;
  logic [9:0]        presc_q;
  t8cw_pkg::t8cw_sel_t wsel;
  t8cw_pkg::t8cw_mode_t mode;
  logic              do_wr, cnt_wr, force_wr, tick, match, pwm, at_max;
  logic [1:0]        com;

  assign do_wr    = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wsel     = decode(awaddr_q);
  assign cnt_wr   = do_wr && wlane_q && wsel == t8cw_pkg::T8CW_SEL_CNT;
  assign force_wr = do_wr && wlane_q && wsel == t8cw_pkg::T8CW_SEL_CB
                    && wdata_q[`T8CW_FOC_BIT];
  assign mode     = t8cw_pkg::t8cw_mode_t'(
                      ctrl_a_q[`T8CW_WGM_HI:`T8CW_WGM_LO]);
  assign com      = ctrl_a_q[`T8CW_COM_HI:`T8CW_COM_LO];
  assign pwm      = ctrl_a_q[`T8CW_WGM_LO];
  assign match    = cnt_q == ocr_act_q;
  assign at_max   = cnt_q == `T8CW_MAX;
  // crystal edge taken as a sampled level; it must be under aclk/2
  assign tick     = cs_q != `T8CW_CS_STOP &&
                    (async_q ? (crystal_clk_in && !xtal_prev_q)
                             : tap_hit(cs_q, presc_q));

  ////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= `T8CW_RST8;
      wlane_q       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `T8CW_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata[7:0];
        wlane_q      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wsel == t8cw_pkg::T8CW_SEL_NONE ?
                        `T8CW_RESP_SLVERR : `T8CW_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel: one cycle from address to data, no read side effects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `T8CW_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `T8CW_RESP_OKAY;
      s_axi_rdata   <= '0;
      unique case (decode(s_axi_araddr))
        t8cw_pkg::T8CW_SEL_CA:  s_axi_rdata[7:0] <= ctrl_a_q;
        t8cw_pkg::T8CW_SEL_CB:  s_axi_rdata[2:0] <= cs_q;
        t8cw_pkg::T8CW_SEL_CNT: s_axi_rdata[7:0] <= cnt_q;
        t8cw_pkg::T8CW_SEL_CMP: s_axi_rdata[7:0] <= ocr_buf_q;
        t8cw_pkg::T8CW_SEL_FLG: s_axi_rdata[1:0] <= {cmf_q, ovf_q};
        t8cw_pkg::T8CW_SEL_MSK: s_axi_rdata[1:0] <= mask_q;
        t8cw_pkg::T8CW_SEL_ASY: s_axi_rdata[0]   <= async_q;
        t8cw_pkg::T8CW_SEL_NONE: s_axi_rresp     <= `T8CW_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_q  <= `T8CW_RST8;
      cs_q      <= `T8CW_CS_STOP;
      ocr_buf_q <= `T8CW_RST8;
      mask_q    <= '0;
      async_q   <= 1'b0;
    end else if (do_wr && wlane_q) begin
      unique case (wsel)
        t8cw_pkg::T8CW_SEL_CA:  ctrl_a_q  <= wdata_q;
        t8cw_pkg::T8CW_SEL_CB:  cs_q <= wdata_q[`T8CW_CS_HI:`T8CW_CS_LO];
        t8cw_pkg::T8CW_SEL_CMP: ocr_buf_q <= wdata_q;
        t8cw_pkg::T8CW_SEL_MSK:
          mask_q <= {wdata_q[`T8CW_CMF_BIT], wdata_q[`T8CW_OVF_BIT]};
        t8cw_pkg::T8CW_SEL_ASY: async_q <= wdata_q[`T8CW_ASYNC_BIT];
        default: ;
      endcase
    end
  end

  // prescaler runs free so taps stay phase-locked to each other
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q     <= '0;
      xtal_prev_q <= 1'b0;
    end else begin
      presc_q     <= presc_q + 10'h001;
      xtal_prev_q <= crystal_clk_in;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counting sequence
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (tick) begin
      unique case (mode)
        t8cw_pkg::T8CW_CTC:
          cnt_d = match ? `T8CW_BOTTOM : cnt_q + 8'h01;
        t8cw_pkg::T8CW_PHASE:
          if (!dir_q && at_max) begin
            dir_d = 1'b1;
            cnt_d = cnt_q - 8'h01;
          end else if (dir_q && cnt_q == `T8CW_BOTTOM) begin
            dir_d = 1'b0;
            cnt_d = cnt_q + 8'h01;
          end else begin
            cnt_d = dir_q ? cnt_q - 8'h01 : cnt_q + 8'h01;
          end
        default: cnt_d = cnt_q + 8'h01;
      endcase
    end
    if (cnt_wr) begin
      cnt_d = wdata_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= `T8CW_RST8;
      dir_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  // compare buffer: follows writes in non-pwm, loads at top in pwm
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ocr_act_q <= `T8CW_RST8;
    end else if (!pwm || (tick && at_max)) begin
      ocr_act_q <= ocr_buf_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over any clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmf_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (tick && match) begin
        cmf_q <= 1'b1;
      end else if (compare_irq_ack) begin
        cmf_q <= 1'b0;
      end else if (do_wr && wlane_q && wsel == t8cw_pkg::T8CW_SEL_FLG
                   && wdata_q[`T8CW_CMF_BIT]) begin
        cmf_q <= 1'b0;
      end
      if (tick && (mode == t8cw_pkg::T8CW_PHASE ?
                   cnt_q == `T8CW_BOTTOM : at_max)) begin
        ovf_q <= 1'b1;
      end else if (overflow_irq_ack ||
                   (do_wr && wlane_q && wsel == t8cw_pkg::T8CW_SEL_FLG
                    && wdata_q[`T8CW_OVF_BIT])) begin
        ovf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_irq  <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      compare_irq  <= cmf_q && mask_q[1];
      overflow_irq <= ovf_q && mask_q[0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // waveform generator; in fast pwm a match beats the bottom set
  always_comb begin
    oc_d = oc_q;
    if (force_wr && !pwm) begin
      unique case (com)
        2'h1:    oc_d = !oc_q;
        2'h2:    oc_d = 1'b0;
        2'h3:    oc_d = 1'b1;
        default: ;
      endcase
    end else if (tick) begin
      unique case (mode)
        t8cw_pkg::T8CW_FAST: begin
          if (at_max && com[1]) oc_d = !com[0];
          if (match && com[1])  oc_d = com[0];
        end
        t8cw_pkg::T8CW_PHASE:
          if (match && com[1]) oc_d = com[0] ^ dir_q;
        default:
          if (match) begin
            unique case (com)
              2'h1:    oc_d = !oc_q;
              2'h2:    oc_d = 1'b0;
              2'h3:    oc_d = 1'b1;
              default: ;
            endcase
          end
      endcase
    end
  end

  // action 0 disconnects: pin parks low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_q               <= 1'b0;
      compare_output_pin <= 1'b0;
    end else begin
      oc_q               <= oc_d;
      compare_output_pin <= com != 2'h0 && oc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_match_tick;
    tick && match;
  endsequence
  sequence s_quiet_cnt;
    !tick && !cnt_wr;
  endsequence

  property p_stop;
    cs_q == `T8CW_CS_STOP && !cnt_wr |=> $stable(cnt_q);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped");
  property p_wr_prio;
    cnt_wr |=> cnt_q == $past(wdata_q);
  endproperty
  a_wr_prio: assert property (p_wr_prio) else $error("count write lost");
  property p_ctc_clear;
    s_match_tick ##0 (mode == t8cw_pkg::T8CW_CTC && !cnt_wr)
      |=> cnt_q == `T8CW_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("no clear on match");
  property p_cmf_set;
    s_match_tick |=> cmf_q;
  endproperty
  a_cmf_set: assert property (p_cmf_set) else $error("compare flag not set");
  property p_cirq;
    cmf_q && mask_q[1] |=> compare_irq;
  endproperty
  a_cirq: assert property (p_cirq) else $error("compare irq missing");
  property p_ack;
    compare_irq_ack && !(tick && match) |=> !cmf_q;
  endproperty
  a_ack: assert property (p_ack) else $error("flag kept after service");
  property p_tov_pc;
    tick && mode == t8cw_pkg::T8CW_PHASE && cnt_q == `T8CW_BOTTOM
      |=> ovf_q;
  endproperty
  a_tov_pc: assert property (p_tov_pc) else $error("bottom overflow missed");
  property p_force;
    force_wr && !cmf_q && !(tick && match) ##0 s_quiet_cnt
      |=> !cmf_q && $stable(cnt_q);
  endproperty
  a_force: assert property (p_force) else $error("force had side effect");
  property p_ocr_pwm;
    pwm && !(tick && at_max) && $stable(pwm) |=> $stable(ocr_act_q);
  endproperty
  a_ocr_pwm: assert property (p_ocr_pwm) else $error("compare loaded early");
endmodule : t8cw_top

// [tb/test_t8cw_top.sv]
// bench for the 8-bit timer with compare and waveform output
// assumes t8cw_top alone; the bench is the AXI4-Lite master
`include "t8cw_defines.svh"
module test_t8cw_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CA  = {2'b00, `T8CW_IDX_CTRL_A, 2'b00};
  localparam logic [11:0] A_CB  = {2'b00, `T8CW_IDX_CTRL_B, 2'b00};
  localparam logic [11:0] A_CNT = {2'b00, `T8CW_IDX_COUNT, 2'b00};
  localparam logic [11:0] A_CMP = {2'b00, `T8CW_IDX_COMPARE, 2'b00};
  localparam logic [11:0] A_FLG = {2'b00, `T8CW_IDX_FLAG, 2'b00};
  localparam logic [11:0] A_MSK = {2'b00, `T8CW_IDX_MASK, 2'b00};
  localparam logic [11:0] A_ASY = {2'b00, `T8CW_IDX_ASYNC, 2'b00};
  localparam logic [11:0] A_BAD = 12'h000;
  localparam logic [1:0]  OK    = `T8CW_RESP_OKAY;
  localparam logic [1:0]  ERR   = `T8CW_RESP_SLVERR;
  localparam int          LIMIT = 60000;
  logic        aclk;
  logic        aresetn;
  logic [11:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        crystal_clk_in;
  logic        compare_irq_ack;
  logic        overflow_irq_ack;
  logic        compare_irq;
  logic        overflow_irq;
  logic        compare_output_pin;
  int          num_errors;
  int          n_tests;
  int          cyc;
  ////////////////////////////////////////////////////////////////////////////
  t8cw_top #(.ADDR_W(12)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .crystal_clk_in(crystal_clk_in),
    .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
    .compare_irq(compare_irq), .overflow_irq(overflow_irq),
    .compare_output_pin(compare_output_pin));
  ////////////////////////////////////////////////////////////////////////////
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      report_and_stop();
    end
  end
  task report_and_stop;
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask : check
  ////////////////////////////////////////////////////////////////////////////
  // readies are judged at the falling edge: outputs are settled there
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w, ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w)) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      aw = aw | ta;
      w = w | tw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    check({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    check({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
  task rc(input logic [11:0] a, input logic [7:0] e, input string m);
    logic [31:0] v;
    rd(a, v, OK);
    check(v, {24'h000000, e}, m);
  endtask : rc
  // bounded wait on one of the two requests, cycles counted in n
  task wait_irq(input bit sel, input int lim, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while ((sel ? compare_irq : overflow_irq) !== 1'b1 && n < lim);
  endtask : wait_irq
  task arm(input logic [7:0] ca, input logic [7:0] cnt, input logic [7:0] m);
    wr(A_CB, 8'h00, OK);
    wr(A_CA, ca, OK);
    wr(A_CNT, cnt, OK);
    wr(A_FLG, 8'h03, OK);
    wr(A_MSK, m, OK);
  endtask : arm
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    logic [11:0] ad [7];
    logic [31:0] v;
    ad = '{A_CA, A_CB, A_CNT, A_CMP, A_FLG, A_MSK, A_ASY};
    foreach (ad[i]) rc(ad[i], 8'h00, "reset value");
    rd(A_BAD, v, ERR);
    check(v, 32'h0, "unmapped read");
    wr(A_BAD, 8'h55, ERR);
    wr(A_CB, 8'hF8, OK);
    rc(A_CB, 8'h00, "strobe and reserved bits");
    wr(A_CNT, 8'h5A, OK);
    repeat (20) @(negedge aclk);
    rc(A_CNT, 8'h5A, "count held while stopped");
  endtask : t_regs
  task t_run;
    logic [31:0] v;
    wr(A_CB, 8'h01, OK);
    wr(A_CNT, 8'h10, OK);
    rd(A_CNT, v, OK);
    wr(A_CB, 8'h00, OK);
    check(v >= 32'h11 && v <= 32'h18, 1, "write beats count");
  endtask : t_run
  task t_divs;
    int dv [7];
    int n;
    dv = '{1, 8, 64, 256, 1024, 32, 128};
    foreach (dv[i]) begin
      arm(8'h00, 8'hFF, 8'h01);
      wr(A_CB, 8'(i + 1), OK);
      wait_irq(0, dv[i] + 20, n);
      check(n <= dv[i] + 12, 1, "tick divisor");
    end
    rc(A_FLG, 8'h01, "overflow flag shown");
    @(posedge aclk) overflow_irq_ack <= 1'b1;
    @(posedge aclk) overflow_irq_ack <= 1'b0;
    repeat (3) @(negedge aclk);
    check(overflow_irq, 1'b0, "overflow serviced");
  endtask : t_divs
  task t_async;
    int n;
    arm(8'h00, 8'hFF, 8'h01);
    wr(A_ASY, 8'h01, OK);
    wr(A_CB, 8'h01, OK);
    repeat (30) @(negedge aclk);
    check(overflow_irq, 1'b0, "no crystal edge no tick");
    @(posedge aclk) crystal_clk_in <= 1'b1;
    wait_irq(0, 12, n);
    check(overflow_irq, 1'b1, "crystal edge ticks");
    @(posedge aclk) crystal_clk_in <= 1'b0;
    wr(A_ASY, 8'h00, OK);
  endtask : t_async
  task t_flags;
    int n;
    arm(8'h00, 8'h30, 8'h03);
    wr(A_CMP, 8'h40, OK);
    wr(A_CB, 8'h01, OK);
    wait_irq(1, 40, n);
    check(n >= 8 && n <= 20, 1, "match flag at compare");
    wr(A_CB, 8'h00, OK);
    wr(A_FLG, 8'h00, OK);
    rc(A_FLG, 8'h02, "zero write keeps flag");
    wr(A_FLG, 8'h02, OK);
    rc(A_FLG, 8'h00, "one write clears flag");
    arm(8'h00, 8'h3E, 8'h01);
    wr(A_CB, 8'h01, OK);
    repeat (8) @(negedge aclk);
    wr(A_CB, 8'h00, OK);
    check(compare_irq, 1'b0, "masked compare request");
    rc(A_FLG, 8'h02, "flag set under mask");
    @(posedge aclk) compare_irq_ack <= 1'b1;
    @(posedge aclk) compare_irq_ack <= 1'b0;
    rc(A_FLG, 8'h00, "compare serviced");
  endtask : t_flags
  task t_modes;
    int n;
    logic [31:0] v;
    arm(8'h02, 8'h00, 8'h01);
    wr(A_CMP, 8'h10, OK);
    wr(A_CB, 8'h01, OK);
    wait_irq(0, 600, n);
    check(overflow_irq, 1'b0, "top is compare value");
    wr(A_CB, 8'h00, OK);
    rd(A_CNT, v, OK);
    check(v <= 32'h10, 1, "count wraps at compare");
    arm(8'h01, 8'hF0, 8'h01);
    wr(A_CB, 8'h01, OK);
    wait_irq(0, 700, n);
    check(n >= 250 && n <= 290, 1, "phase overflow at bottom");
  endtask : t_modes
  task t_force;
    arm(8'h42, 8'h05, 8'h03);
    check(compare_output_pin, 1'b0, "pin before force");
    wr(A_CB, 8'h80, OK);
    @(negedge aclk);
    check(compare_output_pin, 1'b1, "force toggles pin");
    check(compare_irq, 1'b0, "force no request");
    rc(A_CB, 8'h00, "strobe reads zero");
    rc(A_CNT, 8'h05, "force keeps count");
    rc(A_FLG, 8'h00, "force sets no flag");
    wr(A_CB, 8'h80, OK);
    @(negedge aclk);
    check(compare_output_pin, 1'b0, "force toggles back");
  endtask : t_force
  task t_fast;
    int hi;
    arm(8'h83, 8'h00, 8'h00);
    wr(A_CMP, 8'h80, OK);
    // software keeps the strobe zero in pwm modes
    wr(A_CB, 8'h01, OK);
    rc(A_CMP, 8'h80, "buffer reads back");
    repeat (300) @(negedge aclk);
    hi = 0;
    repeat (512) begin
      @(negedge aclk);
      hi += int'(compare_output_pin === 1'b1);
    end
    check(hi >= 250 && hi <= 266, 1, "fast pwm duty");
    wr(A_CB, 8'h00, OK);
  endtask : t_fast
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    crystal_clk_in = 1'b0;
    compare_irq_ack = 1'b0;
    overflow_irq_ack = 1'b0;
    num_errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_run();
    t_divs();
    t_async();
    t_flags();
    t_modes();
    t_force();
    t_fast();
    report_and_stop();
  end
endmodule : test_t8cw_top
